/* src/vrl_top.sv */
// Voltage reference ladder control with an AXI4-Lite register slave.
// Assumes a single clock and an AXI4-Lite master on the same clock.
`timescale 1ns/1ps
`default_nettype none
module vrl_top (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RSTN,
    // AXI4-Lite write address.
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [3:0] S_AXI_AWADDR,
    // AXI4-Lite write data.
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    // AXI4-Lite write response.
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    output logic [1:0] S_AXI_BRESP,
    // AXI4-Lite read address.
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    // AXI4-Lite read data.
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    // Analog ladder controls.
    output logic LADDER_POWER_ENABLE,
    output logic LADDER_PIN_OUTPUT_ENABLE,
    output logic LADDER_SOURCE_SELECT,
    output logic LADDER_RANGE_SELECT,
    output logic [6:0] LADDER_TAP
);
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Write channel state.
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic next_aw_held;
    logic [3:0] next_aw_addr;
    logic next_w_held;
    logic [31:0] next_w_data;
    logic next_w_lane0;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic aw_ready;
    logic w_ready;
    logic next_aw_ready;
    logic next_w_ready;
    // Read channel state.
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic ar_ready;
    logic next_ar_ready;
    // Control register.
    logic [7:0] vref_control_reg;
    logic [7:0] next_vref_control_reg;

    vrl_ctrl_if ctrl ();

    function automatic logic mapped(input logic [3:0] addr);
        mapped = addr == vrl_pkg::VREF_CONTROL_OFFSET
            || addr == vrl_pkg::TAP_STATUS_OFFSET;
    endfunction

    logic do_write;

    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_lane0 = w_lane0;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_vref_control_reg = vref_control_reg;
        do_write = 1'b0;
        if (S_AXI_AWVALID && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_lane0 = S_AXI_WSTRB[0];
        end
        if (aw_held && w_held && !bvalid) begin
            do_write = 1'b1;
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = mapped(aw_addr) ? vrl_pkg::RESP_OKAY
                : vrl_pkg::RESP_SLVERR;
            if (aw_addr == vrl_pkg::VREF_CONTROL_OFFSET && w_lane0) begin
                next_vref_control_reg = w_data[7:0];
            end
        end
        if (bvalid && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
        next_aw_ready = !next_aw_held;
        next_w_ready = !next_w_held;
    end

    always_comb begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (S_AXI_ARVALID && !rvalid) begin
            next_rvalid = 1'b1;
            next_rresp = mapped(S_AXI_ARADDR) ? vrl_pkg::RESP_OKAY
                : vrl_pkg::RESP_SLVERR;
            if (S_AXI_ARADDR == vrl_pkg::VREF_CONTROL_OFFSET) begin
                next_rdata = {24'h00_0000, vref_control_reg};
            end else if (S_AXI_ARADDR == vrl_pkg::TAP_STATUS_OFFSET) begin
                next_rdata = {25'h000_0000, ctrl.tap};
            end else begin
                next_rdata = 32'h0000_0000;
            end
        end else if (rvalid && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
        next_ar_ready = !next_rvalid;
    end

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_lane0 <= 1'b0;
            bvalid <= 1'b0;
            bresp <= vrl_pkg::RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= vrl_pkg::RESP_OKAY;
            aw_ready <= 1'b1;
            w_ready <= 1'b1;
            ar_ready <= 1'b1;
            vref_control_reg <= vrl_pkg::CONTROL_RESET;
        end else begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_lane0 <= next_w_lane0;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            aw_ready <= next_aw_ready;
            w_ready <= next_w_ready;
            ar_ready <= next_ar_ready;
            vref_control_reg <= next_vref_control_reg;
        end
    end

    // level and range feed the decoder.
    assign ctrl.range_low = vref_control_reg[vrl_pkg::RANGE_BIT];
    assign ctrl.level = vref_control_reg[vrl_pkg::LEVEL_MSB:0];

    vrl_tap_decode u_decode (
        .clk(CLOCK),
        .rst_n(rst_n),
        .ctrl(ctrl)
    );

    logic power_q;
    logic pin_oe_q;
    logic source_q;
    logic range_q;

    always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            power_q <= 1'b0;
            pin_oe_q <= 1'b0;
            source_q <= 1'b0;
            range_q <= 1'b0;
        end else begin
            power_q <= vref_control_reg[vrl_pkg::POWER_BIT];
            pin_oe_q <= vref_control_reg[vrl_pkg::PIN_OE_BIT];
            source_q <= vref_control_reg[vrl_pkg::SOURCE_BIT];
            range_q <= vref_control_reg[vrl_pkg::RANGE_BIT];
        end
    end

    assign S_AXI_AWREADY = aw_ready;
    assign S_AXI_WREADY = w_ready;
    assign S_AXI_BVALID = bvalid;
    assign S_AXI_BRESP = bresp;
    assign S_AXI_ARREADY = ar_ready;
    assign S_AXI_RVALID = rvalid;
    assign S_AXI_RDATA = rdata;
    assign S_AXI_RRESP = rresp;
    assign LADDER_POWER_ENABLE = power_q;
    assign LADDER_PIN_OUTPUT_ENABLE = pin_oe_q;
    assign LADDER_SOURCE_SELECT = source_q;
    assign LADDER_RANGE_SELECT = range_q;
    assign LADDER_TAP = ctrl.tap;

    chk_power_follow: assert property (
        @(posedge CLOCK) disable iff (!rst_n)
        ##1 LADDER_POWER_ENABLE == $past(vref_control_reg[7]))
        else $error("Power enable does not follow control bit.");

    chk_pin_route: assert property (
        @(posedge CLOCK) disable iff (!rst_n)
        ##1 LADDER_PIN_OUTPUT_ENABLE == $past(vref_control_reg[6]))
        else $error("Pin routing does not follow control bit.");

    chk_source_sel: assert property (
        @(posedge CLOCK) disable iff (!rst_n)
        ##1 LADDER_SOURCE_SELECT == $past(vref_control_reg[4]))
        else $error("Source select does not follow control bit.");

    chk_write_lands: assert property (
        @(posedge CLOCK) disable iff (!rst_n)
        do_write && aw_addr == 4'h0 && w_lane0
        |=> vref_control_reg == $past(w_data[7:0]))
        else $error("Control write lost.");

    chk_reg_stable: assert property (
        @(posedge CLOCK) disable iff (!rst_n)
        !do_write |=> $stable(vref_control_reg))
        else $error("Control register changed without a write.");

    chk_read_back: assert property (
        @(posedge CLOCK) disable iff (!rst_n)
        S_AXI_ARVALID && !rvalid && S_AXI_ARADDR == 4'h0
        |=> S_AXI_RVALID && S_AXI_RDATA[7:0] == $past(vref_control_reg))
        else $error("Read data mismatch.");

    chk_write_resp: assert property (
        @(posedge CLOCK) disable iff (!rst_n)
        do_write |=> S_AXI_BVALID)
        else $error("Write response missing.");

    chk_reset_clear: assert property (@(posedge CLOCK)
        $rose(rst_n) |-> vref_control_reg == 8'h00 && !LADDER_POWER_ENABLE)
        else $error("Control not cleared by reset.");
endmodule
`default_nettype wire

/* common/vrl_pkg.sv */
// Package for the voltage reference ladder control block.
// Assumes an AXI4-Lite master with 32-bit data drives the register bus.
package vrl_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] VREF_CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] TAP_STATUS_OFFSET = 4'h4;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam int POWER_BIT = 7;
    localparam int PIN_OE_BIT = 6;
    localparam int RANGE_BIT = 5;
    localparam int SOURCE_BIT = 4;
    localparam int LEVEL_MSB = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Low range taps step by span/24 from zero, high range taps by span/32
    // from a quarter; both are expressed on a 96-step ladder of span/96.
    localparam logic [6:0] LOW_STEP = 7'h04;
    localparam logic [6:0] HIGH_STEP = 7'h03;
    localparam logic [6:0] HIGH_BASE = 7'h18;
    localparam logic [3:0] LEVEL_MAX = 4'hf;
endpackage

/* common/vrl_ctrl_if.sv */
// Interface carrying the control settings to the tap decoder.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface vrl_ctrl_if;
    logic range_low;
    logic [3:0] level;
    logic [6:0] tap;
    modport src (output range_low, output level, input tap);
    modport dec (input range_low, input level, output tap);
endinterface
`default_nettype wire

/* src/vrl_tap_decode.sv */
// Tap decoder: turns range and level into a ladder tap index in span/96.
// Assumes settings come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module vrl_tap_decode (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Settings in, tap out.
    vrl_ctrl_if.dec ctrl
);
    logic [6:0] tap;
    logic [6:0] next_tap;

    always_comb begin
        if (ctrl.range_low) begin
            next_tap = 7'(ctrl.level) * vrl_pkg::LOW_STEP;
        end else begin
            next_tap = vrl_pkg::HIGH_BASE
                + 7'(ctrl.level) * vrl_pkg::HIGH_STEP;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tap <= vrl_pkg::HIGH_BASE;
        end else begin
            tap <= next_tap;
        end
    end

    assign ctrl.tap = tap;

    chk_low_tap: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl.range_low |=> tap == 7'($past(ctrl.level)) * 7'h04)
        else $error("Low range tap wrong.");

    chk_high_tap: assert property (@(posedge clk) disable iff (!rst_n)
        !ctrl.range_low |=> tap == 7'h18 + 7'($past(ctrl.level)) * 7'h03)
        else $error("High range tap wrong.");
endmodule
`default_nettype wire

/* dv/voltage_reference_ladder_control_test.sv */
// Self-checking bench for the voltage reference ladder control block.
// Assumes the block answers AXI4-Lite requests on one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module voltage_reference_ladder_control_test;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] awaddr = 4'h0;
    logic [3:0] araddr = 4'h0;
    logic [3:0] wstrb = 4'h0;
    logic [31:0] wdata = 32'h0000_0000;
    logic awready, wready, bvalid, arready, rvalid;
    logic power, pin_oe, source, range_sel;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, data;
    logic [6:0] tap;
    logic [31:0] lfsr = 32'h0000_7689;
    int ctrl = 0;
    int n_mismatch = 0;
    int tests_run = 0;

    vrl_top vrl_top_i (
        .CLOCK(clock), .RSTN(rstn),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_ARADDR(araddr), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .LADDER_POWER_ENABLE(power), .LADDER_PIN_OUTPUT_ENABLE(pin_oe),
        .LADDER_SOURCE_SELECT(source), .LADDER_RANGE_SELECT(range_sel),
        .LADDER_TAP(tap)
    );

    always #4 clock = ~clock;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Tap position on a ladder of 96 steps of the source span.
    function automatic int exp_tap();
        if (ctrl[5]) begin
            return (ctrl & 15) * (96 / 24);
        end
        return 96 / 4 + (ctrl & 15) * (96 / 32);
    endfunction

    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_write(input logic [3:0] addr, input logic [31:0] d,
                             input logic [3:0] strb, output logic [1:0] resp);
        logic aw_hs, w_hs, done;
        awaddr <= addr;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(negedge clock);
            aw_hs = awvalid && awready;
            w_hs = wvalid && wready;
            done = bvalid;
            resp = bresp;
            @(posedge clock);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic axi_read(input logic [3:0] addr, output logic [31:0] d,
                            output logic [1:0] resp);
        logic ar_hs, done;
        araddr <= addr;
        arvalid <= 1'b1;
        rready <= 1'b1;
        done = 1'b0;
        while (!done) begin
            @(negedge clock);
            ar_hs = arvalid && arready;
            done = rvalid;
            if (done) check("arready_busy", arready, 1'b0);
            d = rdata;
            resp = rresp;
            @(posedge clock);
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        @(posedge clock);
    endtask

    task automatic write_chk(input logic [3:0] addr, input logic [31:0] d,
                             input logic [3:0] strb, input logic [1:0] er);
        logic [1:0] r;
        axi_write(addr, d, strb, r);
        check("bresp", r, er);
    endtask

    task automatic check_reg(input logic [3:0] addr, input int exp,
                             input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(addr, d, r);
        check("rdata", d, exp);
        check("rresp", r, er);
    endtask

    task automatic check_ladder();
        @(negedge clock);
        check("power", power, (ctrl >> 7) & 1);
        check("pin_oe", pin_oe, (ctrl >> 6) & 1);
        check("range", range_sel, (ctrl >> 5) & 1);
        check("source", source, (ctrl >> 4) & 1);
        check("tap", tap, exp_tap());
        check("awready", awready, 1'b1);
        check("wready", wready, 1'b1);
        check("arready", arready, 1'b1);
        check("bvalid", bvalid, 1'b0);
        check("rvalid", rvalid, 1'b0);
        @(posedge clock);
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        check_ladder();
        check_reg(vrl_pkg::VREF_CONTROL_OFFSET, 0, vrl_pkg::RESP_OKAY);
        for (int i = 0; i < 32; i++) begin
            lfsr = lfsr_next(lfsr);
            data = {lfsr[31:8], lfsr[7:6], i[4], lfsr[4], i[3:0]};
            write_chk(vrl_pkg::VREF_CONTROL_OFFSET, data, 4'hf,
                      vrl_pkg::RESP_OKAY);
            ctrl = data[7:0];
            check_ladder();
            check_reg(vrl_pkg::VREF_CONTROL_OFFSET, ctrl,
                      vrl_pkg::RESP_OKAY);
            check_reg(vrl_pkg::TAP_STATUS_OFFSET, exp_tap(),
                      vrl_pkg::RESP_OKAY);
        end
        write_chk(vrl_pkg::VREF_CONTROL_OFFSET, ~data, 4'he,
                  vrl_pkg::RESP_OKAY);
        write_chk(vrl_pkg::TAP_STATUS_OFFSET, 32'h0000_0000, 4'hf,
                  vrl_pkg::RESP_OKAY);
        check_reg(vrl_pkg::TAP_STATUS_OFFSET, exp_tap(),
                  vrl_pkg::RESP_OKAY);
        for (int a = 8; a < 16; a += 4) begin
            write_chk(a[3:0], 32'h0000_00ff, 4'hf, vrl_pkg::RESP_SLVERR);
            check_reg(a[3:0], 0, vrl_pkg::RESP_SLVERR);
        end
        check_reg(vrl_pkg::VREF_CONTROL_OFFSET, ctrl,
                  vrl_pkg::RESP_OKAY);
        repeat (200) @(posedge clock);
        check_ladder();
        check_reg(vrl_pkg::VREF_CONTROL_OFFSET, ctrl,
                  vrl_pkg::RESP_OKAY);
        rstn <= 1'b0;
        repeat (8) @(posedge clock);
        ctrl = 0;
        check_ladder();
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        check_reg(vrl_pkg::VREF_CONTROL_OFFSET, 0, vrl_pkg::RESP_OKAY);
        report_and_stop();
    end
endmodule
`default_nettype wire
